// ### hw/cal_latch_regs.svh
`ifndef CAL_LATCH_REGS_SVH
`define CAL_LATCH_REGS_SVH

// Register byte offsets
`define REG_CTRL_OFS 8'h00
`define REG_LATCHED_OFS 8'h04
`define REG_STATUS_OFS 8'h08
`define REG_DIV_OFS 8'h0c

// Control register fields
`define CTRL_SEL_LSB 0
`define CTRL_SEL_MSB 1
`define CTRL_GAIN 2
`define CTRL_STROBE 3
`define CTRL_RESET_N 4
`define CTRL_EXT_EN 5

// Status register fields
`define STAT_OSC 0
`define STAT_LOCKED 1
`define STAT_SYNC_IN 2

// Reset values
`define CTRL_RESET_VAL 8'h10

// Timing: 40 MHz clock, 50 kHz nominal oscillator, toggle at twice that rate
`define CLK_HZ 40000000
`define OSC_HZ 50000
`define OSC_HALF_CYCLES ((`CLK_HZ / `OSC_HZ) / 2)
`define LOCK_TIMEOUT_CYCLES (`OSC_HALF_CYCLES * 4)

`endif

// ### hw/cal_latch_pkg.sv
package cal_latch_pkg;
  typedef enum logic [1:0] {
    SRC_COMMON,
    SRC_REF_LOW,
    SRC_REF_HIGH,
    SRC_SIGNAL
  } source_t;

  typedef enum logic {
    GAIN_HALF,
    GAIN_FIFTY
  } gain_t;
endpackage

// ### hw/sync_oscillator.sv
`timescale 1ns/100ps
`include "cal_latch_regs.svh"

// Free-running 50 kHz oscillator that phase-locks to a sync clock edge
module sync_oscillator (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sync_rise,
  input wire logic [15:0] half_period,
  output logic osc_out,
  output logic locked
);
  logic [15:0] cnt_r;
  logic osc_r;
  logic locked_r;
  logic [17:0] idle_r;
  wire logic wrap;
  wire logic idle_expired;

  // Counter wraps at the programmed half period; a sync edge restarts the phase
  assign wrap = (cnt_r >= half_period - 16'h0001);
  assign idle_expired = (idle_r == 18'(`LOCK_TIMEOUT_CYCLES));

  // Runs from reset release with no enable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 16'h0000;
      osc_r <= 1'b0;
    end else if (sync_rise) begin
      cnt_r <= 16'h0000;
      osc_r <= 1'b1;
    end else if (wrap) begin
      cnt_r <= 16'h0000;
      osc_r <= ~osc_r;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // Lock drops if sync edges stop, so the oscillator falls back to free running
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idle_r <= 18'h00000;
      locked_r <= 1'b0;
    end else if (sync_rise) begin
      idle_r <= 18'h00000;
      locked_r <= 1'b1;
    end else if (idle_expired) begin
      locked_r <= 1'b0;
    end else begin
      idle_r <= idle_r + 18'h00001;
    end
  end

  assign osc_out = osc_r;
  assign locked = locked_r;
endmodule

// ### hw/calibration_select_latch.sv
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
`include "cal_latch_regs.svh"

// Function
// - Two select pins choose source, gain pin chooses gain
// - Oscillator free-runs from reset at 50kHz
// - Shared sync clock locks oscillator phase
// - External clock on sync input drives oscillator
module calibration_select_latch (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic input_sel_lsb,
  input wire logic input_sel_msb,
  input wire logic gain_sel,
  input wire logic latch_strobe,
  input wire logic latch_rst_n,
  input wire logic sync_clock_in,
  output cal_latch_pkg::source_t source_sel,
  output cal_latch_pkg::gain_t gain_out,
  output logic osc_out,
  output logic osc_locked
);
  // Pin synchronisers: first stage read only by second stage
  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  logic sync_d_r;
  // Software control: select, gain, strobe, latch reset, sync enable
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [15:0] div_r;
  logic [15:0] div_nxt;
  logic strobe_prev_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic [1:0] sel_r;
  logic gain_r;

  wire logic req;
  wire logic wr_ctrl;
  wire logic wr_div;
  wire logic hit_ctrl;
  wire logic hit_latched;
  wire logic hit_status;
  wire logic hit_div;
  wire logic [1:0] pin_sel;
  wire logic pin_gain;
  wire logic pin_strobe;
  wire logic pin_rst_n;
  wire logic [1:0] ctrl_sel;
  wire logic ctrl_gain;
  wire logic ctrl_strobe;
  wire logic ctrl_rst_n;
  wire logic ctrl_ext_en;
  wire logic [1:0] eff_sel;
  wire logic eff_gain;
  wire logic eff_strobe;
  wire logic eff_rst_n;
  wire logic strobe_rise;
  wire logic sync_rise;
  wire logic [2:0] latched_word;
  wire logic [2:0] status_word;
  wire logic [31:0] rd_mux;
  wire logic osc_w;
  wire logic locked_w;

  // Merge a byte-enabled write into an 8-bit lane
  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] nw,
                                        input logic en);
    merge8 = en ? nw : old;
  endfunction

  // Word address against a byte offset; the two low byte bits are implied
  function automatic logic reg_hit(input logic [3:0] addr, input logic [7:0] ofs);
    reg_hit = ({2'b00, addr, 2'b00} == ofs);
  endfunction

  // Pins cross two flops before use
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_r <= 5'h10;
      pin_s2_r <= 5'h10;
    end else begin
      pin_s1_r <= {latch_rst_n, latch_strobe, gain_sel, input_sel_msb, input_sel_lsb};
      pin_s2_r <= pin_s1_r;
    end
  end

  // Sync input gets its own pair so edge detection sees only the second stage
  logic sync_s1_r;
  logic sync_s2_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_s1_r <= 1'b0;
      sync_s2_r <= 1'b0;
      sync_d_r <= 1'b0;
    end else begin
      sync_s1_r <= sync_clock_in;
      sync_s2_r <= sync_s1_r;
      sync_d_r <= sync_s2_r;
    end
  end

  // Pin fields after the second sync stage
  assign pin_sel = pin_s2_r[1:0];
  assign pin_gain = pin_s2_r[2];
  assign pin_strobe = pin_s2_r[3];
  assign pin_rst_n = pin_s2_r[4];

  // Software copies of the same controls
  assign ctrl_sel = ctrl_r[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
  assign ctrl_gain = ctrl_r[`CTRL_GAIN];
  assign ctrl_strobe = ctrl_r[`CTRL_STROBE];
  assign ctrl_rst_n = ctrl_r[`CTRL_RESET_N];
  assign ctrl_ext_en = ctrl_r[`CTRL_EXT_EN];

  // Pin and software paths combine: either can strobe, either can clear
  assign eff_sel = pin_sel | ctrl_sel;
  assign eff_gain = pin_gain | ctrl_gain;
  assign eff_strobe = pin_strobe | ctrl_strobe;
  assign eff_rst_n = pin_rst_n & ctrl_rst_n;
  assign strobe_rise = eff_strobe & ~strobe_prev_r;
  // Sync edges ignored unless enabled, so a floating pin cannot disturb timing
  assign sync_rise = ctrl_ext_en & sync_s2_r & ~sync_d_r;

  // Previous strobe level; resets to the idle low level so reset gives no false edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strobe_prev_r <= 1'b0;
    end else begin
      strobe_prev_r <= eff_strobe;
    end
  end

  // Select and gain latch: clear dominates, rising strobe loads, else hold
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_r <= 2'h0;
      gain_r <= 1'b0;
    end else if (!eff_rst_n) begin
      sel_r <= 2'h0;
      gain_r <= 1'b0;
    end else if (strobe_rise) begin
      sel_r <= eff_sel;
      gain_r <= eff_gain;
    end
  end

  // Latched codes drive the source mux and the amplifier directly
  assign source_sel = cal_latch_pkg::source_t'(sel_r);
  assign gain_out = cal_latch_pkg::gain_t'(gain_r);

  // Avalon slave: one wait cycle, then the access completes with waitrequest low
  assign req = (avs_read | avs_write) & ~ack_r;
  assign avs_waitrequest = ~ack_r;
  // Address decode, shared by the write strobes and the readback
  assign hit_ctrl = reg_hit(avs_address, `REG_CTRL_OFS);
  assign hit_latched = reg_hit(avs_address, `REG_LATCHED_OFS);
  assign hit_status = reg_hit(avs_address, `REG_STATUS_OFS);
  assign hit_div = reg_hit(avs_address, `REG_DIV_OFS);
  // Writes land on the edge at which the master sees waitrequest low, never before
  assign wr_ctrl = avs_write & ack_r & hit_ctrl;
  assign wr_div = avs_write & ack_r & hit_div;

  always_comb begin
    ctrl_nxt = ctrl_r;
    div_nxt = div_r;
    if (wr_ctrl) begin
      ctrl_nxt = merge8(ctrl_r, avs_writedata[7:0], avs_byteenable[0]);
    end
    if (wr_div) begin
      div_nxt[7:0] = merge8(div_r[7:0], avs_writedata[7:0], avs_byteenable[0]);
      div_nxt[15:8] = merge8(div_r[15:8], avs_writedata[15:8], avs_byteenable[1]);
    end
  end

  // Readback: latched state and oscillator status; unmapped reads zero
  assign latched_word = {gain_r, sel_r};
  assign status_word = {sync_s2_r, locked_w, osc_w};
  assign rd_mux =
    hit_ctrl ? {24'h000000, ctrl_r} :
    hit_latched ? {29'h00000000, latched_word} :
    hit_status ? {29'h00000000, status_word} :
    hit_div ? {16'h0000, div_r} :
    32'h00000000;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= `CTRL_RESET_VAL;
      div_r <= 16'(`OSC_HALF_CYCLES);
      ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ctrl_r <= ctrl_nxt;
      div_r <= div_nxt;
      ack_r <= req;
      if (req && avs_read) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // Read data from a flop, standing while waitrequest is low
  assign avs_readdata = rdata_r;

  // Oscillator, locked to the sync input when enabled
  sync_oscillator u_osc (
    .clk(clk),
    .rstn(rstn),
    .sync_rise(sync_rise),
    .half_period(div_r),
    .osc_out(osc_w),
    .locked(locked_w)
  );

  // Oscillator outputs come straight from its flops
  assign osc_out = osc_w;
  assign osc_locked = locked_w;
endmodule

// ### test/cal_latch_monitor.sv
`timescale 1ns/100ps
// Pin-level view of the latch and the oscillator
module cal_latch_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic avs_write,
  input wire logic input_sel_lsb,
  input wire logic input_sel_msb,
  input wire logic gain_sel,
  input wire logic latch_strobe,
  input wire logic latch_rst_n,
  input wire logic sync_clock_in,
  input wire cal_latch_pkg::source_t source_sel,
  input wire cal_latch_pkg::gain_t gain_out,
  input wire logic osc_out,
  input wire logic osc_locked
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Strobe rise with settled code latches it; sync flops cost cycles
  AST_LATCH: assert property ($rose(latch_strobe) && latch_rst_n ##1
    (latch_rst_n && $stable({input_sel_msb, input_sel_lsb, gain_sel}))[*5]
    |-> {gain_out, source_sel} == {gain_sel, input_sel_msb, input_sel_lsb})
    else $error("strobe did not latch");
  AST_CLEAR: assert property (!latch_rst_n [*4] |->
    {gain_out, source_sel} == 3'h0) else $error("clear ignored");
  // Steady strobe and no bus write leave the latch alone
  AST_HOLD: assert property (($stable(latch_strobe) && latch_rst_n && !avs_write) [*6] |=>
    $stable(source_sel) && $stable(gain_out)) else $error("latch moved");
  // Runs free from reset with no enable
  AST_OSC: assert property (##[1:900] $changed(osc_out)) else $error("osc stuck");
  // Lock only follows a sync edge, and that edge restarts the phase high
  AST_LOCK: assert property ($rose(osc_locked) |-> $past(sync_clock_in, 3) && osc_out)
    else $error("lock without sync edge");
endmodule
bind calibration_select_latch cal_latch_monitor cal_latch_monitor_i (.clk(clk), .rstn(rstn),
  .avs_write(avs_write), .input_sel_lsb(input_sel_lsb), .input_sel_msb(input_sel_msb),
  .gain_sel(gain_sel), .latch_strobe(latch_strobe), .latch_rst_n(latch_rst_n),
  .sync_clock_in(sync_clock_in),
  .source_sel(source_sel), .gain_out(gain_out), .osc_out(osc_out), .osc_locked(osc_locked));

// ### test/cal_host.sv
`timescale 1ns/100ps
// Host pins: code settles first, strobe rises later
module cal_host (
  input wire logic clk,
  input wire logic go,
  input wire logic [2:0] code,
  input wire logic clr_n,
  output logic sel_lsb,
  output logic sel_msb,
  output logic gsel,
  output logic strobe,
  output logic rst_n
);
  logic [2:0] ph_r = 3'h0;
  initial {gsel, sel_msb, sel_lsb, strobe, rst_n} = 5'h1;
  // Set gain and source, then strobe, as in a calibration step
  always @(posedge clk) begin
    ph_r <= go ? 3'h1 : ph_r + {2'h0, ph_r != 3'h0};
    if (go) {gsel, sel_msb, sel_lsb, strobe} <= {code, 1'b0};
    if (ph_r == 3'h3) strobe <= 1'b1;
    rst_n <= clr_n;
  end
endmodule

// ### test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] a = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat, q;
  logic wait_r, sl, sm, gs, st, rn, osc, lck;
  logic sync = 1'b0;
  logic go = 1'b0;
  logic clr_n = 1'b1;
  logic [2:0] code = 3'h0;
  logic [2:0] prev = 3'h0;
  logic [2:0] seq [8] = '{3'h0, 3'h2, 3'h1, 3'h3, 3'h4, 3'h6, 3'h5, 3'h7};
  cal_latch_pkg::source_t src;
  cal_latch_pkg::gain_t gn;
  time t0;
  int mismatches = 0;
  int num_checks = 0;
  always #12.5 clk = ~clk;
  calibration_select_latch calibration_select_latch_i (.clk(clk), .rstn(rstn),
    .avs_address(a), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wait_r),
    .input_sel_lsb(sl), .input_sel_msb(sm), .gain_sel(gs), .latch_strobe(st),
    .latch_rst_n(rn), .sync_clock_in(sync), .source_sel(src), .gain_out(gn),
    .osc_out(osc), .osc_locked(lck));
  cal_host cal_host_i (.clk(clk), .go(go), .code(code), .clr_n(clr_n), .sel_lsb(sl),
    .sel_msb(sm), .gsel(gs), .strobe(st), .rst_n(rn));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d);
    a <= ad;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wait_r !== 1'b0) @(posedge clk);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic strobe_code(input logic [2:0] c);
    code <= c;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h10);
    bus(1'b0, 4'h3, 32'h0);
    chk(q, 32'h190);
    bus(1'b0, 4'h7, 32'h0);
    chk(q, 32'h0);
    // Every code at both gains; old value must stand until the strobe
    foreach (seq[i]) begin
      strobe_code(seq[i]);
      chk({29'h0, gn, src}, {29'h0, prev});
      repeat (8) @(posedge clk);
      chk({29'h0, gn, src}, {29'h0, seq[i]});
      bus(1'b0, 4'h1, 32'h0);
      chk(q, {29'h0, seq[i]});
      prev = seq[i];
    end
    clr_n <= 1'b0;
    strobe_code(3'h7);
    repeat (5) @(posedge clk);
    chk({29'h0, gn, src}, 32'h0);
    clr_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk({29'h0, gn, src}, 32'h0);
    bus(1'b1, 4'h3, 32'h14);
    bus(1'b0, 4'h3, 32'h0);
    chk(q, 32'h14);
    @(posedge osc);
    @(posedge osc);
    t0 = $time;
    @(negedge osc);
    chk(32'(($time - t0) / 25), 32'h14);
    bus(1'b1, 4'h0, 32'h30);
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h30);
    repeat (3) begin
      sync <= 1'b1;
      repeat (5) @(posedge clk);
      chk({31'h0, osc}, 32'h1);
      repeat (25) @(posedge clk);
      sync <= 1'b0;
      repeat (30) @(posedge clk);
    end
    chk({31'h0, lck}, 32'h1);
    bus(1'b0, 4'h2, 32'h0);
    chk(q & 32'h00000006, 32'h00000002);
    repeat (1700) @(posedge clk);
    chk({31'h0, lck}, 32'h0);
    bus(1'b0, 4'h2, 32'h0);
    chk(q & 32'h00000006, 32'h00000000);
    summarize();
  end
  // Run needs under 4000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule
